// *** hdl/bridge_channel.sv ***
// One bridge channel: input decoding, chopping, blanking and overcurrent retry.
// Assumes inputs synchronous to mclk; enable low holds the channel idle.
`timescale 1ns/1ps
module bridge_channel #(
	parameter int RETRY_CYCLES = hbridge_pkg::RETRY_CYC
) (
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	input  wire logic                    enable,
	input  wire hbridge_pkg::ctrl_pair_t ctrl,
	input  wire logic                    sense_trip,
	input  wire logic                    fet_limit,
	output hbridge_pkg::gate_t           gate,
	output logic                         oc_fault
);
	// ----------------------------------------------------------------
	// State and timers
	// ----------------------------------------------------------------
	hbridge_pkg::ch_state_t     state;
	hbridge_pkg::ch_state_t     next_state;
	logic [hbridge_pkg::CNT_W-1:0] timer;
	logic [hbridge_pkg::CNT_W-1:0] deg_cnt;
	logic                       driving;
	logic                       prev_driving;
	logic                       oc_hit;
	hbridge_pkg::gate_t         next_gate;

	// Bridge is actively sourcing current (forward or reverse)
	assign driving = ctrl.first ^ ctrl.second;
	assign oc_hit  = fet_limit && (deg_cnt >= hbridge_pkg::CNT_W'(hbridge_pkg::DEGLITCH_CYC - 1));

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			deg_cnt <= hbridge_pkg::CNT_ZERO;
		end else if (!fet_limit || state != hbridge_pkg::CH_RUN) begin
			deg_cnt <= hbridge_pkg::CNT_ZERO;
		end else if (!oc_hit) begin
			deg_cnt <= deg_cnt + hbridge_pkg::CNT_ONE;
		end
	end

	// Next state selection
	always_comb begin
		next_state = state;
		unique case (state)
			hbridge_pkg::CH_IDLE: begin
				if (enable) begin
					next_state = hbridge_pkg::CH_RUN;
				end
			end
			hbridge_pkg::CH_RUN: begin
				if (!enable) begin
					next_state = hbridge_pkg::CH_IDLE;
				end else if (oc_hit) begin
					next_state = hbridge_pkg::CH_TRIP;
				// chop after blanking; never on the edge that starts the drive
				end else if (driving && prev_driving && sense_trip && timer == hbridge_pkg::CNT_ZERO) begin
					next_state = hbridge_pkg::CH_OFF;
				end
			end
			hbridge_pkg::CH_OFF: begin
				if (!enable) begin
					next_state = hbridge_pkg::CH_IDLE;
				end else if (timer == hbridge_pkg::CNT_ZERO) begin
					next_state = hbridge_pkg::CH_RUN;
				end
			end
			hbridge_pkg::CH_TRIP: begin
				if (!enable) begin
					next_state = hbridge_pkg::CH_IDLE;
				end else if (timer == hbridge_pkg::CNT_ZERO) begin
					next_state = hbridge_pkg::CH_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= hbridge_pkg::CH_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prev_driving <= 1'b0;
		end else begin
			prev_driving <= driving && state == hbridge_pkg::CH_RUN;
		end
	end

	// per channel timer: blank, off time, retry
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			timer <= hbridge_pkg::CNT_ZERO;
		end else if (state != hbridge_pkg::CH_TRIP && next_state == hbridge_pkg::CH_TRIP) begin
			timer <= hbridge_pkg::CNT_W'(RETRY_CYCLES - 1);
		end else if (state == hbridge_pkg::CH_RUN && next_state == hbridge_pkg::CH_OFF) begin
			timer <= hbridge_pkg::CNT_W'(hbridge_pkg::OFF_CYC - 1);
		end else if (next_state == hbridge_pkg::CH_RUN
			&& (state != hbridge_pkg::CH_RUN || (driving && !prev_driving))) begin
			timer <= hbridge_pkg::CNT_W'(hbridge_pkg::BLANK_CYC - 1);
		end else if (timer != hbridge_pkg::CNT_ZERO) begin
			timer <= timer - hbridge_pkg::CNT_ONE;
		end
	end

	// input decode into gate drive; coast leaves all off
	always_comb begin
		next_gate = hbridge_pkg::GATE_OFF;
		unique case (next_state)
			hbridge_pkg::CH_RUN: begin
				next_gate.hs_first  = ctrl.first && !ctrl.second;
				next_gate.ls_first  = ctrl.second;
				next_gate.hs_second = ctrl.second && !ctrl.first;
				next_gate.ls_second = ctrl.first;
			end
			hbridge_pkg::CH_OFF: begin
				// slow decay, both low sides on
				next_gate.ls_first  = 1'b1;
				next_gate.ls_second = 1'b1;
			end
			hbridge_pkg::CH_TRIP,
			hbridge_pkg::CH_IDLE: begin
				next_gate = hbridge_pkg::GATE_OFF;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gate     <= hbridge_pkg::GATE_OFF;
			oc_fault <= 1'b0;
		end else begin
			gate     <= next_gate;
			oc_fault <= next_state == hbridge_pkg::CH_TRIP;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_off_time_len: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(state == hbridge_pkg::CH_OFF) |-> (state == hbridge_pkg::CH_OFF) [*8])
		else $error("off time ended early");
	a_trip_gates_off: assert property (@(posedge mclk) disable iff (!rst_b)
		oc_hit && enable |=> oc_fault && gate == hbridge_pkg::GATE_OFF)
		else $error("overcurrent did not shut the bridge");
	a_slow_decay_gate: assert property (@(posedge mclk) disable iff (!rst_b)
		state == hbridge_pkg::CH_OFF |-> gate.ls_first && gate.ls_second && !gate.hs_first && !gate.hs_second)
		else $error("slow decay drive wrong");
	a_no_shoot_through: assert property (@(posedge mclk) disable iff (!rst_b)
		!(gate.hs_first && gate.ls_first) && !(gate.hs_second && gate.ls_second))
		else $error("half bridge shoot through");
	a_blank_ignore: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(state == hbridge_pkg::CH_RUN) |=> (state != hbridge_pkg::CH_OFF) [*8])
		else $error("chop during blanking");
endmodule

// *** hdl/hbridge_pkg.sv ***
// Package: shared constants, states and carriers for the dual bridge driver control.
// Assumes a single 25 MHz clock; analog comparators arrive as synchronous levels.
package hbridge_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 25;
	localparam int BLANK_NS         = 3750;                               // Blanking after enable
	localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;  // Least time, round up
	localparam int OFF_NS           = 23000;                              // Fixed off time
	localparam int OFF_CYC          = (OFF_NS * CLK_MHZ + 999) / 1000;
	localparam int DEGLITCH_NS      = 1000;                               // Overcurrent deglitch
	localparam int DEGLITCH_CYC     = (DEGLITCH_NS * CLK_MHZ) / 1000;     // Longest time, round down
	localparam int RETRY_US         = 1400;                               // Overcurrent retry
	localparam int RETRY_CYC        = RETRY_US * CLK_MHZ;
	localparam int SLEEP_NS         = 1000;                               // Sleep entry delay
	localparam int SLEEP_CYC        = (SLEEP_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_NS          = 1000;                               // Wake-up interval
	localparam int WAKE_CYC         = (WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W            = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CH_RUN   = 4'h1,   // Decoded drive, blanking or sensing
		CH_OFF   = 4'h2,   // Chopping slow decay
		CH_TRIP  = 4'h4,   // Overcurrent shutdown, retry wait
		CH_IDLE  = 4'h8    // Sleep, thermal or not yet awake
	} ch_state_t;

	// Control input pair of one bridge
	typedef struct packed {
		logic first;
		logic second;
	} ctrl_pair_t;

	// Gate drive of one bridge: high and low sides of each half
	typedef struct packed {
		logic hs_first;
		logic ls_first;
		logic hs_second;
		logic ls_second;
	} gate_t;

	localparam gate_t GATE_OFF = 4'h0;

endpackage

// *** hdl/dual_hbridge_drive_control.sv ***
// File: top level of the dual bridge control logic.
// Assumes comparator and limit levels synchronous to mclk; the pad ring
// resolves high impedance from the output enables.
`timescale 1ns/1ps
module dual_hbridge_drive_control #(
	parameter int RETRY_CYCLES = hbridge_pkg::RETRY_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       bridge_a_ctrl_first,
	input  wire logic       bridge_a_ctrl_second,
	input  wire logic       bridge_b_ctrl_first,
	input  wire logic       bridge_b_ctrl_second,
	input  wire logic       sleep_request_low,
	input  wire logic       undervoltage_lockout,
	input  wire logic       thermal_cutoff,
	input  wire logic [1:0] sense_trip,
	input  wire logic [1:0] fet_limit_high,
	input  wire logic [1:0] fet_limit_low,
	output logic            bridge_a_drive_first,
	output logic            bridge_a_drive_first_oe,
	output logic            bridge_a_drive_second,
	output logic            bridge_a_drive_second_oe,
	output logic            bridge_b_drive_first,
	output logic            bridge_b_drive_first_oe,
	output logic            bridge_b_drive_second,
	output logic            bridge_b_drive_second_oe,
	output hbridge_pkg::gate_t [1:0] gate_drive,
	output logic            fault_flag_low,
	output logic            fault_flag_low_oe
);
	// ----------------------------------------------------------------
	// Internal reset and power state
	// ----------------------------------------------------------------
	logic                          core_rst_b;
	logic                          asleep;
	logic                          awake;
	logic [hbridge_pkg::CNT_W-1:0] sleep_cnt;
	logic [hbridge_pkg::CNT_W-1:0] wake_cnt;
	logic                          ch_enable;
	hbridge_pkg::ctrl_pair_t [1:0] ctrl;
	hbridge_pkg::gate_t [1:0]      gate;
	logic [1:0]                    oc_fault;

	assign core_rst_b = rst_b && !undervoltage_lockout;

	always_ff @(posedge mclk or negedge core_rst_b) begin
		if (!core_rst_b) begin
			sleep_cnt <= hbridge_pkg::CNT_ZERO;
			asleep    <= 1'b0;
		end else if (sleep_request_low) begin
			sleep_cnt <= hbridge_pkg::CNT_ZERO;
			asleep    <= 1'b0;
		end else if (sleep_cnt >= hbridge_pkg::CNT_W'(hbridge_pkg::SLEEP_CYC - 1)) begin
			asleep    <= 1'b1;
		end else begin
			sleep_cnt <= sleep_cnt + hbridge_pkg::CNT_ONE;
		end
	end

	// wake-up interval after sleep or reset
	always_ff @(posedge mclk or negedge core_rst_b) begin
		if (!core_rst_b) begin
			wake_cnt <= hbridge_pkg::CNT_ZERO;
			awake    <= 1'b0;
		end else if (asleep) begin
			wake_cnt <= hbridge_pkg::CNT_ZERO;
			awake    <= 1'b0;
		end else if (!sleep_request_low) begin
			wake_cnt <= wake_cnt;
		end else if (wake_cnt >= hbridge_pkg::CNT_W'(hbridge_pkg::WAKE_CYC - 1)) begin
			awake    <= 1'b1;
		end else begin
			wake_cnt <= wake_cnt + hbridge_pkg::CNT_ONE;
		end
	end

	// bridges enabled only awake and cool
	assign ch_enable = awake && !asleep && !thermal_cutoff;

	assign ctrl[0] = '{first: bridge_a_ctrl_first && awake, second: bridge_a_ctrl_second && awake};
	assign ctrl[1] = '{first: bridge_b_ctrl_first && awake, second: bridge_b_ctrl_second && awake};

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	// two independent channels
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		bridge_channel #(
			.RETRY_CYCLES (RETRY_CYCLES)
		) u_channel (
			.mclk       (mclk),
			.rst_b      (core_rst_b),
			.enable     (ch_enable),
			.ctrl       (ctrl[ch]),
			.sense_trip (sense_trip[ch]),
			.fet_limit  (fet_limit_high[ch] || fet_limit_low[ch]),
			.gate       (gate[ch]),
			.oc_fault   (oc_fault[ch])
		);
	end

	// ----------------------------------------------------------------
	// Output pins
	// ----------------------------------------------------------------
	// Pad levels and enables registered from the gates; Z when neither side on
	always_ff @(posedge mclk or negedge core_rst_b) begin
		if (!core_rst_b) begin
			bridge_a_drive_first     <= 1'b0;
			bridge_a_drive_first_oe  <= 1'b0;
			bridge_a_drive_second    <= 1'b0;
			bridge_a_drive_second_oe <= 1'b0;
			bridge_b_drive_first     <= 1'b0;
			bridge_b_drive_first_oe  <= 1'b0;
			bridge_b_drive_second    <= 1'b0;
			bridge_b_drive_second_oe <= 1'b0;
			gate_drive               <= {hbridge_pkg::GATE_OFF, hbridge_pkg::GATE_OFF};
		end else begin
			bridge_a_drive_first     <= gate[0].hs_first;
			bridge_a_drive_first_oe  <= gate[0].hs_first || gate[0].ls_first;
			bridge_a_drive_second    <= gate[0].hs_second;
			bridge_a_drive_second_oe <= gate[0].hs_second || gate[0].ls_second;
			bridge_b_drive_first     <= gate[1].hs_first;
			bridge_b_drive_first_oe  <= gate[1].hs_first || gate[1].ls_first;
			bridge_b_drive_second    <= gate[1].hs_second;
			bridge_b_drive_second_oe <= gate[1].hs_second || gate[1].ls_second;
			gate_drive               <= gate;
		end
	end

	always_ff @(posedge mclk or negedge core_rst_b) begin
		if (!core_rst_b) begin
			fault_flag_low_oe <= 1'b0;
		end else begin
			fault_flag_low_oe <= (thermal_cutoff && awake) || (|oc_fault);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fault_flag_low <= 1'b0;
		end else begin
			fault_flag_low <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_uv_no_fault: assert property (@(posedge mclk) disable iff (!rst_b)
		undervoltage_lockout |-> !fault_flag_low_oe)
		else $error("fault driven during undervoltage");
	a_sleep_outputs_off: assert property (@(posedge mclk) disable iff (!core_rst_b)
		asleep |-> ##2 !bridge_a_drive_first_oe && !bridge_a_drive_second_oe
			&& !bridge_b_drive_first_oe && !bridge_b_drive_second_oe)
		else $error("bridge driven while asleep");
	a_thermal_fault_pin: assert property (@(posedge mclk) disable iff (!core_rst_b)
		thermal_cutoff && awake |=> fault_flag_low_oe)
		else $error("thermal fault not flagged");
	a_brake_both_low: assert property (@(posedge mclk) disable iff (!core_rst_b)
		gate_drive[0].ls_first && gate_drive[0].ls_second |-> !bridge_a_drive_first && !bridge_a_drive_second
			&& bridge_a_drive_first_oe && bridge_a_drive_second_oe)
		else $error("brake drive wrong");
endmodule

// *** verif/motor_controller_model.sv ***
// Partner model: the external controller that drives the bridge control inputs.
// Assumes the bench changes code and pwm selects just after a falling edge.
`timescale 1ns/1ps
module motor_controller_model #(
	parameter int PWM_HALF = 200
) (
	input  wire logic       mclk,
	input  wire logic       pwm_a,
	input  wire logic [1:0] code_a,
	input  wire logic [1:0] code_b,
	output logic            a_first,
	output logic            a_second,
	output logic            b_first,
	output logic            b_second
);
	int   cnt   = 0;
	logic phase = 1'b0;

	// PWM phase, moves only on the falling edge
	always @(negedge mclk) begin
		cnt = (cnt == PWM_HALF - 1) ? 0 : cnt + 1;
		if (cnt == 0) begin
			phase = ~phase;
		end
	end

	// PWM pin selection
	// With pwm_a: 10 fwd fast, 01 rev fast, 11 fwd slow, 00 rev slow
	always_comb begin
		{a_first, a_second} = code_a;
		if (pwm_a) begin
			case (code_a)
				2'h2:    {a_first, a_second} = {phase, 1'b0};
				2'h1:    {a_first, a_second} = {1'b0, phase};
				2'h3:    {a_first, a_second} = {1'b1, phase};
				default: {a_first, a_second} = {phase, 1'b1};
			endcase
		end
		{b_first, b_second} = code_b;
	end
endmodule

// *** verif/dual_hbridge_drive_control_test.sv ***
// Testbench: decode, protection and sleep scenarios for both bridges; chopping for bridge A only.
// Assumes a 25 MHz clock and a shortened overcurrent retry period.
`timescale 1ns/1ps
module dual_hbridge_drive_control_test;
	localparam int RETRY = 50;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	logic       pwm_a = 1'b0;
	logic [1:0] code_a = 2'h0;
	logic [1:0] code_b = 2'h0;
	logic       sleep_request_low = 1'b1;
	logic       undervoltage_lockout = 1'b0;
	logic       thermal_cutoff = 1'b0;
	logic [1:0] sense_trip = 2'h0;
	logic [1:0] fet_limit_high = 2'h0;
	logic [1:0] fet_limit_low = 2'h0;
	logic       a1, a2, b1, b2, ad1, ae1, ad2, ae2, bd1, be1, bd2, be2, fl, fl_oe;
	hbridge_pkg::gate_t [1:0] gate_drive;
	int         n_errors = 0;
	int         num_checks = 0;
	int         cycle_count = 0;
	wire logic [3:0] pads_a = {ad1, ae1, ad2, ae2};
	wire logic [3:0] pads_b = {bd1, be1, bd2, be2};

	motor_controller_model ctrl_src (.mclk(mclk), .pwm_a(pwm_a), .code_a(code_a), .code_b(code_b),
		.a_first(a1), .a_second(a2), .b_first(b1), .b_second(b2));

	dual_hbridge_drive_control #(.RETRY_CYCLES(RETRY)) dut (.mclk(mclk), .rst_b(rst_b),
		.bridge_a_ctrl_first(a1), .bridge_a_ctrl_second(a2), .bridge_b_ctrl_first(b1),
		.bridge_b_ctrl_second(b2), .sleep_request_low(sleep_request_low),
		.undervoltage_lockout(undervoltage_lockout), .thermal_cutoff(thermal_cutoff),
		.sense_trip(sense_trip), .fet_limit_high(fet_limit_high), .fet_limit_low(fet_limit_low),
		.bridge_a_drive_first(ad1), .bridge_a_drive_first_oe(ae1), .bridge_a_drive_second(ad2),
		.bridge_a_drive_second_oe(ae2), .bridge_b_drive_first(bd1), .bridge_b_drive_first_oe(be1),
		.bridge_b_drive_second(bd2), .bridge_b_drive_second_oe(be2), .gate_drive(gate_drive),
		.fault_flag_low(fl), .fault_flag_low_oe(fl_oe));

	// Clock and cycle ceiling
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycle_count++;
		if (cycle_count == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check_val(input string what, input logic [3:0] exp, input logic [3:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_gate(input int b, input logic [3:0] exp, input int lim);
		for (int i = 0; i < lim && gate_drive[b] !== exp; i++) @(negedge mclk);
		check_val("gate", exp, gate_drive[b]);
	endtask

	task automatic hold_gate(input int b, input logic [3:0] exp, input int n);
		logic [3:0] seen;
		seen = exp;
		repeat (n) begin
			@(negedge mclk);
			if (gate_drive[b] !== exp) seen = gate_drive[b];
		end
		check_val("gate hold", exp, seen);
	endtask

	task automatic wait_fault(input logic exp, input int lim);
		for (int i = 0; i < lim && fl_oe !== exp; i++) @(negedge mclk);
		check_val("fault pull", {3'h0, exp}, {3'h0, fl_oe});
		check_val("fault data", 4'h0, {3'h0, fl});
	endtask

	function automatic logic [3:0] exp_gate(input logic [1:0] c);
		return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h6 : (c == 2'h2) ? 4'h9 : 4'h5;
	endfunction

	function automatic logic [3:0] exp_pad(input logic [1:0] c);
		return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h7 : (c == 2'h2) ? 4'hD : 4'h5;
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_decode();
		for (int i = 0; i < 4; i++) begin
			code_a = 2'(i);
			code_b = 2'(3 - i);
			wait_gate(0, exp_gate(code_a), 6);
			wait_gate(1, exp_gate(code_b), 6);
			repeat (2) @(negedge mclk);
			check_val("pads a", exp_pad(code_a), pads_a & ((i == 0) ? 4'h5 : 4'hF));
			check_val("pads b", exp_pad(code_b), pads_b & ((i == 3) ? 4'h5 : 4'hF));
		end
	endtask

	task automatic test_chop();
		code_a = 2'h0;
		code_b = 2'h1;
		wait_gate(0, 4'h0, 6);
		code_a = 2'h2;
		wait_gate(0, 4'h9, 6);
		repeat (20) @(negedge mclk);
		sense_trip[0] = 1'b1;
		hold_gate(0, 4'h9, 40);
		sense_trip[0] = 1'b0;
		repeat (50) @(negedge mclk);
		sense_trip[0] = 1'b1;
		wait_gate(0, 4'h5, 4);
		sense_trip[0] = 1'b0;
		hold_gate(0, 4'h5, hbridge_pkg::OFF_CYC - 10);
		wait_gate(0, 4'h9, 30);
		check_val("other bridge", 4'h6, gate_drive[1]);
	endtask

	task automatic test_pwm();
		pwm_a = 1'b1;
		wait_gate(0, 4'h0, 420);
		wait_gate(0, 4'h9, 420);
		code_a = 2'h3;
		wait_gate(0, 4'h5, 420);
		wait_gate(0, 4'h9, 420);
		sense_trip[0] = 1'b1;
		wait_gate(0, 4'h5, 120);
		sense_trip[0] = 1'b0;
		pwm_a = 1'b0;
		code_a = 2'h2;
		wait_gate(0, 4'h9, 700);
	endtask

	task automatic test_overcurrent();
		int cnt;
		fet_limit_high[0] = 1'b1;
		repeat (10) @(negedge mclk);
		fet_limit_high[0] = 1'b0;
		hold_gate(0, 4'h9, 5);
		check_val("short glitch", 4'h0, {3'h0, fl_oe});
		fet_limit_high[0] = 1'b1;
		wait_fault(1'b1, hbridge_pkg::DEGLITCH_CYC + 5);
		check_val("gate a off", 4'h0, gate_drive[0]);
		check_val("gate b on", 4'h6, gate_drive[1]);
		fet_limit_high[0] = 1'b0;
		cnt = 0;
		while (fl_oe === 1'b1 && cnt < RETRY + 20) begin
			@(negedge mclk);
			cnt++;
		end
		check_val("retry time", 4'h1, {3'h0, cnt >= RETRY - 5 && cnt <= RETRY + 5});
		wait_gate(0, 4'h9, 10);
		fet_limit_low[1] = 1'b1;
		wait_fault(1'b1, hbridge_pkg::DEGLITCH_CYC + 5);
		check_val("gate b off", 4'h0, gate_drive[1]);
		check_val("gate a on", 4'h9, gate_drive[0]);
		wait_fault(1'b0, RETRY + 10);
		wait_fault(1'b1, hbridge_pkg::DEGLITCH_CYC + 10);
		fet_limit_low[1] = 1'b0;
		wait_fault(1'b0, RETRY + 10);
		wait_gate(1, 4'h6, 10);
	endtask

	task automatic test_thermal();
		thermal_cutoff = 1'b1;
		wait_gate(0, 4'h0, 5);
		wait_gate(1, 4'h0, 5);
		wait_fault(1'b1, 5);
		thermal_cutoff = 1'b0;
		wait_gate(0, 4'h9, 60);
		wait_fault(1'b0, 60);
	endtask

	task automatic test_undervoltage();
		undervoltage_lockout = 1'b1;
		#1;
		check_val("uv gate a", 4'h0, gate_drive[0]);
		check_val("uv gate b", 4'h0, gate_drive[1]);
		check_val("uv pads", 4'h0, (pads_a | pads_b) & 4'h5);
		repeat (5) @(negedge mclk);
		check_val("uv fault", 4'h0, {3'h0, fl_oe});
		undervoltage_lockout = 1'b0;
		wait_gate(0, 4'h9, 80);
		check_val("uv fault after", 4'h0, {3'h0, fl_oe});
	endtask

	task automatic test_sleep();
		sleep_request_low = 1'b0;
		hold_gate(0, 4'h9, hbridge_pkg::SLEEP_CYC - 3);
		wait_gate(0, 4'h0, 10);
		check_val("sleep pads", 4'h0, (pads_a | pads_b) & 4'h5);
		code_a = 2'h1;
		hold_gate(0, 4'h0, 30);
		sleep_request_low = 1'b1;
		hold_gate(0, 4'h0, hbridge_pkg::WAKE_CYC - 3);
		wait_gate(0, 4'h6, 20);
		repeat (2) @(negedge mclk);
		check_val("wake pads", 4'h7, pads_a);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(negedge mclk);
		rst_b = 1'b1;
		repeat (40) @(negedge mclk);
		test_decode();
		test_chop();
		test_pwm();
		test_overcurrent();
		test_thermal();
		test_undervoltage();
		test_sleep();
		final_report();
	end
endmodule
